// >>> core/pbt_pkg.sv
// Constants for the prescaler and time-base counter block.
// Assumes a 32-bit AHB-Lite register bus and a single clock, hclk.
package pbt_pkg;
    localparam int unsigned fast_width = 11;
    localparam int unsigned watch_width = 8;
    localparam int unsigned count_width = 8;
    localparam int unsigned mode_width = 4;
    localparam int unsigned sub_div_width = 3;
    // Mode register index as printed; byte address is four times it
    localparam logic [11:0] mode_index = 12'h00f;
    localparam logic [11:0] mode_addr = 12'h03c;
    localparam logic [11:0] status_addr = 12'h040;
    localparam logic [11:0] mask_addr = 12'h044;
    localparam logic [11:0] count_addr = 12'h048;
    localparam logic [3:0] mode_reset = 4'h0;
    localparam logic [fast_width-1:0] fast_reset = 11'h000;
    localparam logic [watch_width-1:0] watch_reset = 8'h00;
    localparam logic [count_width-1:0] count_reset = 8'h00;
    localparam logic [count_width-1:0] count_max = 8'hff;
    localparam int unsigned overflow_bit = 0;
    // Fast and watch prescaler tap masks: all ones in the low bits marks a period end
    localparam logic [fast_width-1:0] fast_tap_2048 = 11'h7ff;
    localparam logic [fast_width-1:0] fast_tap_1024 = 11'h3ff;
    localparam logic [fast_width-1:0] fast_tap_512 = 11'h1ff;
    localparam logic [fast_width-1:0] fast_tap_128 = 11'h07f;
    localparam logic [fast_width-1:0] fast_tap_32 = 11'h01f;
    localparam logic [fast_width-1:0] fast_tap_8 = 11'h007;
    localparam logic [fast_width-1:0] fast_tap_4 = 11'h003;
    localparam logic [fast_width-1:0] fast_tap_2 = 11'h001;
    localparam logic [watch_width-1:0] watch_tap_32 = 8'h1f;
    localparam logic [watch_width-1:0] watch_tap_16 = 8'h0f;
    localparam logic [watch_width-1:0] watch_tap_8 = 8'h07;
    localparam logic [watch_width-1:0] watch_tap_2 = 8'h01;
    localparam logic [sub_div_width-1:0] sub_div_last = 3'h7;
endpackage

// >>> core/pbt_top.sv
// Prescalers and 8-bit time-base counter with an AHB-Lite register slave.
// Assumes operating-mode inputs come from logic on hclk; the sub-oscillator
// clock arrives as a pin and is sampled, not used as a clock.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps
module pbt_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sub_clk,
    input wire logic stop_mode,
    input wire logic watch_mode,
    input wire logic subactive_mode,
    output logic [10:0] fast_prescaler,
    output logic [7:0] watch_prescaler,
    output logic display_halt,
    output logic irq
);
    logic [10:0] fast_q;
    logic [7:0] watch_q;
    logic [7:0] count_q;
    logic [3:0] mode_q;
    logic [0:0] status_q;
    logic [0:0] status_d;
    logic [0:0] mask_q;
    logic [2:0] sub_div_q;
    logic sub_s1_q, sub_s2_q, sub_s3_q;
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic acc, rd_acc;
    logic sub_edge, watch_in_tick, fast_run, fast_step;
    logic tb_clear, tick, overflow, status_rd;
    logic [31:0] rdata;

    // Sub-oscillator pin: two-flop synchroniser, edge from the second stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
        end else begin
            sub_s1_q <= sub_clk;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
        end
    end
    assign sub_edge = sub_s2_q & ~sub_s3_q;

    // Divide-by-eight ahead of the watch prescaler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_div_q <= '0;
        end else if (sub_edge && !stop_mode) begin
            sub_div_q <= sub_div_q + 3'h1;
        end
    end
    assign watch_in_tick = sub_edge && !stop_mode &&
        (sub_div_q == pbt_pkg::sub_div_last);

    assign fast_run = !stop_mode && !watch_mode;
    assign fast_step = fast_run && (subactive_mode ? sub_edge : 1'b1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_q <= pbt_pkg::fast_reset;
        end else if (fast_step) begin
            fast_q <= fast_q + 11'h001;
        end
    end

    assign tb_clear = mode_q[3] && mode_q[2] && mode_q[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            watch_q <= pbt_pkg::watch_reset;
        end else if (tb_clear) begin
            watch_q <= pbt_pkg::watch_reset;
        end else if (watch_in_tick) begin
            watch_q <= watch_q + 8'h01;
        end
    end

    // Counter tick: a tap fires when its low prescaler bits are all ones
    always_comb begin
        tick = 1'b0;
        if (!mode_q[3]) begin
            case (mode_q[2:0])
                3'h0: tick = (fast_q & pbt_pkg::fast_tap_2048) ==
                    pbt_pkg::fast_tap_2048;
                3'h1: tick = (fast_q & pbt_pkg::fast_tap_1024) ==
                    pbt_pkg::fast_tap_1024;
                3'h2: tick = (fast_q & pbt_pkg::fast_tap_512) ==
                    pbt_pkg::fast_tap_512;
                3'h3: tick = (fast_q & pbt_pkg::fast_tap_128) ==
                    pbt_pkg::fast_tap_128;
                3'h4: tick = (fast_q & pbt_pkg::fast_tap_32) ==
                    pbt_pkg::fast_tap_32;
                3'h5: tick = (fast_q & pbt_pkg::fast_tap_8) ==
                    pbt_pkg::fast_tap_8;
                3'h6: tick = (fast_q & pbt_pkg::fast_tap_4) ==
                    pbt_pkg::fast_tap_4;
                default: tick = (fast_q & pbt_pkg::fast_tap_2) ==
                    pbt_pkg::fast_tap_2;
            endcase
            tick = tick && fast_step;
        end else begin
            case (mode_q[2:0])
                3'h0: tick = (watch_q & pbt_pkg::watch_tap_32) ==
                    pbt_pkg::watch_tap_32;
                3'h1: tick = (watch_q & pbt_pkg::watch_tap_16) ==
                    pbt_pkg::watch_tap_16;
                3'h2: tick = (watch_q & pbt_pkg::watch_tap_8) ==
                    pbt_pkg::watch_tap_8;
                3'h3: tick = (watch_q & pbt_pkg::watch_tap_2) ==
                    pbt_pkg::watch_tap_2;
                3'h4: tick = 1'b1;
                default: tick = 1'b0;
            endcase
            tick = tick && watch_in_tick && !tb_clear;
        end
    end

    assign overflow = tick && (count_q == pbt_pkg::count_max);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= pbt_pkg::count_reset;
        end else if (tb_clear) begin
            count_q <= pbt_pkg::count_reset;
        end else if (tick) begin
            count_q <= count_q + 8'h01;
        end
    end

    // Bus: zero wait states, every transfer answered OKAY
    assign acc = hsel && hready && htrans[1];
    assign rd_acc = acc && !hwrite;
    assign status_rd = rd_acc && (haddr[11:0] == pbt_pkg::status_addr);

    always_comb begin
        rdata = 32'h0000_0000;
        case (haddr[11:0])
            pbt_pkg::status_addr: rdata[0] = status_q[0];
            pbt_pkg::mask_addr: rdata[0] = mask_q[0];
            pbt_pkg::count_addr: rdata[7:0] = count_q;
            default: rdata = 32'h0000_0000; // Mode reads zero: write-only
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend_q <= acc && hwrite;
            if (acc) begin
                wr_addr_q <= haddr[11:0];
            end
            if (rd_acc) begin
                hrdata <= rdata;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= pbt_pkg::mode_reset;
            mask_q <= '0;
        end else if (wr_pend_q) begin
            if (wr_addr_q == pbt_pkg::mode_addr) begin
                mode_q <= hwdata[3:0];
            end
            if (wr_addr_q == pbt_pkg::mask_addr) begin
                mask_q <= hwdata[0:0];
            end
        end
    end

    // Set beats the read-clear so an overflow in the read cycle survives
    always_comb begin
        status_d = status_q;
        if (status_rd) begin
            status_d = '0;
        end
        if (overflow) begin
            status_d[pbt_pkg::overflow_bit] = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= '0;
            irq <= 1'b0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            fast_prescaler <= pbt_pkg::fast_reset;
            watch_prescaler <= pbt_pkg::watch_reset;
            display_halt <= 1'b0;
        end else begin
            status_q <= status_d;
            irq <= |(status_d & mask_q);
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            fast_prescaler <= fast_q;
            watch_prescaler <= watch_q;
            display_halt <= tb_clear;
        end
    end
endmodule // pbt_top

// >>> tb/pbt_top_sva.sv
// Checker for the prescaler and time-base block, bound to pbt_top.
// Assumes one clock, hclk, and asynchronous active-low hresetn.
`timescale 1ns/10ps
module pbt_top_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic stop_mode,
    input wire logic watch_mode,
    input wire logic subactive_mode,
    input wire logic [10:0] fast_prescaler,
    input wire logic [7:0] watch_prescaler,
    input wire logic display_halt
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence fast_run;
        (!stop_mode && !watch_mode && !subactive_mode) [*3];
    endsequence
    sequence mode_rd;
        hsel && hready && htrans[1] && !hwrite
            && haddr[11:0] == pbt_pkg::mode_addr;
    endsequence
    // Address phase then data phase carrying the clearing code
    sequence clear_wr;
        hsel && hready && htrans[1] && hwrite
            && haddr[11:0] == pbt_pkg::mode_addr
            ##1 hwdata[3:1] == 3'h7;
    endsequence
    AST_FAST_ZERO: assert property (
        $rose(hresetn) |-> fast_prescaler == pbt_pkg::fast_reset)
        else $error("fast prescaler not zero after reset");
    AST_FAST_RUN: assert property (
        fast_run |=> fast_prescaler == $past(fast_prescaler) + 11'h001)
        else $error("fast prescaler did not step by one");
    AST_FAST_HALT: assert property (
        (stop_mode || watch_mode) [*4] |=> $stable(fast_prescaler))
        else $error("fast prescaler moved while halted");
    AST_WATCH_HALT: assert property (
        stop_mode [*4] |=> $stable(watch_prescaler))
        else $error("watch prescaler moved in stop");
    AST_MODE_WO: assert property (
        mode_rd |=> hrdata == 32'h0)
        else $error("mode register read not zero");
    AST_HALT_ON: assert property (
        clear_wr |-> ##[1:2] display_halt)
        else $error("display halt missing on clearing code");
    AST_WATCH_CLR: assert property (
        clear_wr |-> ##[1:4] watch_prescaler == pbt_pkg::watch_reset)
        else $error("watch prescaler not cleared");
    AST_READY: assert property ($past(hresetn) |-> hreadyout)
        else $error("wait state inserted");
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("response not okay");
endmodule // pbt_top_sva
bind pbt_top pbt_top_sva i_pbt_top_sva (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .stop_mode(stop_mode),
    .watch_mode(watch_mode), .subactive_mode(subactive_mode),
    .fast_prescaler(fast_prescaler), .watch_prescaler(watch_prescaler),
    .display_halt(display_halt));

// >>> tb/test_prescalers_and_time_base_timer.sv
// Self-checking bench for pbt_top through its AHB-Lite register port.
// Assumes hready loops back from the single slave's hreadyout.
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    mismatches++; $display("MISMATCH %0t value differs", $time); end end
module test_prescalers_and_time_base_timer;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sub_clk = 0;
    logic stop_mode = 0, watch_mode = 0, subactive_mode = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r0, r1;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, display_halt, irq;
    logic [10:0] fast_prescaler, f0;
    logic [7:0] watch_prescaler, w0;
    wire hready = hreadyout;
    int mismatches = 0, samples_checked = 0, cyc = 0;
    // Counter periods in hclk; sub_clk period 6 makes a watch tick 48
    int per[13] = '{2048, 1024, 512, 128, 32, 8, 4, 2,
        1536, 768, 384, 96, 48};
    pbt_top i_pbt_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sub_clk(sub_clk),
        .stop_mode(stop_mode), .watch_mode(watch_mode),
        .subactive_mode(subactive_mode), .fast_prescaler(fast_prescaler),
        .watch_prescaler(watch_prescaler), .display_halt(display_halt),
        .irq(irq));
    initial forever #50 hclk = ~hclk;
    always begin
        repeat (3) @(posedge hclk);
        sub_clk <= ~sub_clk;
    end
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // Values seen right after an edge are still the pre-edge ones
    task automatic bus(input logic [11:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, r1);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        bus(a, 1'b0, 32'h0, q);
    endtask
    initial begin
        tick(10);
        hresetn <= 1'b1;
        tick(1);
        `CHK(fast_prescaler, pbt_pkg::fast_reset)
        `CHK(watch_prescaler, pbt_pkg::watch_reset)
        `CHK(irq, 1'b0)
        rd(pbt_pkg::count_addr, r0);
        `CHK(r0[7:0], pbt_pkg::count_reset)
        rd(12'h100, r0);
        `CHK(r0, 32'h0)
        for (int c = 0; c < 13; c++) begin
            wr(pbt_pkg::mode_addr, 32'(c));
            tick(per[c]);
            rd(pbt_pkg::count_addr, r0);
            tick(2 * per[c] - 2);
            rd(pbt_pkg::count_addr, r1);
            `CHK(8'(r1 - r0), 8'h02)
        end
        rd(pbt_pkg::mode_addr, r0);
        `CHK(r0, 32'h0)
        // Unused time-base code: the counter must not move at all
        wr(pbt_pkg::mode_addr, 32'hd);
        rd(pbt_pkg::count_addr, r0);
        tick(200);
        rd(pbt_pkg::count_addr, r1);
        `CHK(8'(r1 - r0), 8'h00)
        for (int c = 14; c < 16; c++) begin
            wr(pbt_pkg::mode_addr, 32'(c));
            tick(3);
            `CHK(display_halt, 1'b1)
            `CHK(watch_prescaler, pbt_pkg::watch_reset)
            rd(pbt_pkg::count_addr, r0);
            `CHK(r0[7:0], pbt_pkg::count_reset)
        end
        wr(pbt_pkg::mask_addr, 32'h1);
        rd(pbt_pkg::status_addr, r0);
        tick(1);
        `CHK(irq, 1'b0)
        wr(pbt_pkg::mode_addr, 32'h7);
        tick(500);
        `CHK(irq, 1'b0)
        tick(25);
        `CHK(irq, 1'b1)
        rd(pbt_pkg::status_addr, r0);
        `CHK(r0[0], 1'b1)
        tick(1);
        `CHK(irq, 1'b0)
        wr(pbt_pkg::mask_addr, 32'h0);
        tick(520);
        `CHK(irq, 1'b0)
        rd(pbt_pkg::status_addr, r0);
        `CHK(r0[0], 1'b1)
        stop_mode <= 1'b1;
        tick(5);
        f0 = fast_prescaler;
        w0 = watch_prescaler;
        tick(100);
        `CHK(fast_prescaler, f0)
        `CHK(watch_prescaler, w0)
        stop_mode <= 1'b0;
        watch_mode <= 1'b1;
        tick(5);
        f0 = fast_prescaler;
        w0 = watch_prescaler;
        tick(100);
        `CHK(fast_prescaler, f0)
        `CHK(watch_prescaler != w0, 1'b1)
        watch_mode <= 1'b0;
        subactive_mode <= 1'b1;
        tick(5);
        f0 = fast_prescaler;
        tick(60);
        `CHK(11'(fast_prescaler - f0), 11'h00a)
        wrap_up();
    end
endmodule // test_prescalers_and_time_base_timer
